//--- swk_pkg.sv
// Shared constants for the selective-wake controller and its host end.
// Assumes one 20 MHz clock shared by both ends and an 8-bit register port.
package swk_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

    // Bus silence timeout window, in milliseconds.
    localparam int unsigned SILENCE_MIN_MS = 600;
    localparam int unsigned SILENCE_MAX_MS = 1200;
    // Least time in cycles, from whole cycles per millisecond.
    localparam int unsigned SILENCE_CYCLES = (CLK_HZ / 1000) * SILENCE_MIN_MS;
    localparam int unsigned SILENCE_W = 24;

    // Default oscillator measurement pulse driven by the host.
    localparam int unsigned MEAS_PULSE_NS = 1000;
    localparam int unsigned MEAS_PULSE_CYCLES = (MEAS_PULSE_NS * CLK_MHZ + 999) / 1000;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;

    // Register addresses on the device port.
    localparam logic [4:0] A_MODE = 5'h00;
    localparam logic [4:0] A_FLAGS = 5'h01;
    localparam logic [4:0] A_ECNT = 5'h02;
    localparam logic [4:0] A_CTRL = 5'h03;
    localparam logic [4:0] A_QUANTA = 5'h04;
    localparam logic [4:0] A_SAMPLE = 5'h05;
    localparam logic [4:0] A_RCLK = 5'h06;
    localparam logic [4:0] A_OSC_HI = 5'h07;
    localparam logic [4:0] A_OSC_LO = 5'h08;
    localparam logic [4:0] A_TRIM = 5'h09;
    localparam logic [4:0] A_TRIM_OPT = 5'h0a;
    localparam logic [4:0] A_MATCH_ID = 5'h0b;
    localparam logic [4:0] A_MATCH_MASK = 5'h0c;
    localparam logic [4:0] A_MATCH_LEN = 5'h0d;
    localparam logic [4:0] A_MATCH_DATA = 5'h0e;
    // Host-local registers.
    localparam logic [4:0] A_PULSE_LEN = 5'h10;
    localparam logic [4:0] A_PULSE_GO = 5'h11;

    // Flag register bit positions.
    localparam int unsigned F_BUS_WAKE = 0;
    localparam int unsigned F_WAKE_PATTERN = 1;
    localparam int unsigned F_WAKE_FRAME = 2;
    localparam int unsigned F_CFG_ERR = 3;

    // Control register bit positions.
    localparam int unsigned C_FD_TOL = 0;
    localparam int unsigned C_ERR_DIS = 1;
    localparam int unsigned C_OSC_MEAS = 2;
    localparam int unsigned C_RX_SEL = 3;
    localparam int unsigned C_UNLOCK_LO = 4;
    localparam logic [1:0] TRIM_UNLOCKED = 2'h3;

    // Transceiver mode codes; bit 2 selects selective wake.
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_WK = 3'h1;
    localparam logic [2:0] MODE_SWK = 3'h5;
    localparam int unsigned MODE_SEL_BIT = 2;

    localparam logic [5:0] ECNT_OVF = 6'h20;

    // Reset values.
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SAMPLE_RST = 8'h33;

    typedef enum logic [1:0] {
        DEC_IDLE = 2'b00,
        DEC_FRAME = 2'b01,
        DEC_SKIP = 2'b10
    } dec_state_t;

endpackage : swk_pkg

//--- swk_link_if.sv
// Link between the host end and the selective-wake device end.
// Assumes both ends run on the same clock; the transmit pin is one-way.
`timescale 1ns/1ns
`default_nettype none
interface swk_link_if;
    import swk_pkg::*;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic transmit_input_pin;

    modport dev (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        input transmit_input_pin
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        output transmit_input_pin
    );
endinterface : swk_link_if
`default_nettype wire

//--- swk_host_end.sv
// Host end: forwards software register accesses to the device and drives
// the oscillator measurement pulse on the transmit pin.
// Assumes a software port with read data returned one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module swk_host_end
    import swk_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_pulse_busy,
    swk_link_if.host link
);
    logic [7:0] pulse_len_q, pulse_len_d;
    logic [7:0] pulse_cnt_q, pulse_cnt_d;
    logic busy_q, busy_d;
    logic txd_q, txd_d;
    logic [7:0] own_rdata_q, own_rdata_d;
    wire host_sel = i_addr[4];
    wire go = i_wr && (i_addr == A_PULSE_GO) && !busy_q;
    wire pulse_last = busy_q && (pulse_cnt_q == 8'h01);

    // Device accesses pass straight through so the device answers in one cycle.
    assign link.addr = i_addr;
    assign link.wdata = i_wdata;
    assign link.wr = i_wr && !host_sel;
    assign link.rd = i_rd && !host_sel;
    assign link.transmit_input_pin = txd_q;
    // The device returns zero for host addresses, so the two halves combine.
    assign o_rdata = link.rdata | own_rdata_q;
    assign o_pulse_busy = busy_q;

    // The pulse is low for the programmed count, then the pin returns high.
    assign pulse_len_d = (i_wr && i_addr == A_PULSE_LEN) ? i_wdata : pulse_len_q;
    assign busy_d = go ? (pulse_len_q != 8'h00) : (busy_q && !pulse_last);
    assign pulse_cnt_d = go ? pulse_len_q : (busy_q ? pulse_cnt_q - 8'h01 : 8'h00);
    assign txd_d = !busy_d;
    assign own_rdata_d = !i_rd ? 8'h00 :
                         (i_addr == A_PULSE_LEN) ? pulse_len_q :
                         (i_addr == A_PULSE_GO) ? {7'h00, busy_q} : 8'h00;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_len_q <= 8'(MEAS_PULSE_CYCLES);
            pulse_cnt_q <= 8'h00;
            busy_q <= 1'b0;
            txd_q <= 1'b1;
            own_rdata_q <= 8'h00;
        end else begin
            pulse_len_q <= pulse_len_d;
            pulse_cnt_q <= pulse_cnt_d;
            busy_q <= busy_d;
            txd_q <= txd_d;
            own_rdata_q <= own_rdata_d;
        end
    end

endmodule : swk_host_end
`default_nettype wire

//--- swk_device_end.sv
// Device end: transceiver mode and wake flags, frame error counter,
// flexible-data-rate tolerant frame tracking, oscillator measure and trim.
// Assumes a frame decoder on this clock reports frame events; the bus
// receive level and the transmit pin arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Restart from normal keeps Off modes
// - Restart maps 001-011 to wake-capable 001
// - Restart maps selective modes to 101, error set
// - Non-bus restart from sleep clears wake flags
// - Wake pattern in 001 sets wake flags
// - Matching frame sets frame flag, maybe pattern
// - Counter overflow wakes, sets error, reads 100000
// - Frame wake after silence also sets pattern flag
// - Fail-safe forces plain wake-capable mode
// - Bus wake pulses wake and sets flag
// - Software programs bit timing and receiver
// - Software programs frame match registers
// - Pulse on transmit pin measured in cycles
// - Trim writes need unlock 11 and measure
// - Tolerant mode skips and never wakes FD
// - Skipping ends at end-of-frame
// - EDL bit classifies frame, stops decoding
// - Tolerant off: FD/bad up, good down
// - Tolerant on: down on good; both held zero
// - Count disable clears on silence timeout
// - Silence timeout within 0.6 to 1.2 s
// - Mode bit 2 selects selective wake
module swk_device_end
    import swk_pkg::*;
#(
    parameter int unsigned SILENCE_CNT = SILENCE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    swk_link_if.dev link,
    input wire logic i_rxd,
    input wire logic i_restart,
    input wire logic i_restart_from_sleep,
    input wire logic i_sleep_entry,
    input wire logic i_failsafe_entry,
    input wire logic i_sof,
    input wire logic i_ctrl_field,
    input wire logic i_edl,
    input wire logic i_eof,
    input wire logic i_frame_ok,
    input wire logic i_frame_match,
    input wire logic i_wake_pattern,
    output logic o_can_wake,
    output logic o_swk_active,
    output logic o_decoder_ready,
    output logic o_fd_tolerant_enable,
    output logic o_wake_receiver_select,
    output logic [7:0] o_bit_quanta,
    output logic [7:0] o_sample_point,
    output logic [7:0] o_recovery_clock,
    output logic [7:0] o_osc_trim_value,
    output logic [7:0] o_osc_trim_option,
    output logic [7:0] o_match_identifier,
    output logic [7:0] o_match_identifier_mask,
    output logic [7:0] o_match_length,
    output logic [7:0] o_match_payload
);
    function automatic logic selective(input logic [2:0] m);
        selective = m[MODE_SEL_BIT] && (m[1:0] != 2'b00);
    endfunction : selective

    logic [2:0] mode_q, mode_d;
    logic [3:0] flags_q, flags_d;
    logic [5:0] ecnt_q, ecnt_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cfg_q [A_QUANTA:A_MATCH_DATA];
    logic armed_q, armed_d;
    logic silence_seen_q, silence_seen_d;
    logic [SILENCE_W-1:0] sil_q, sil_d;
    logic [15:0] osc_q, osc_d;
    logic [7:0] rdata_q, rdata_d;
    logic wake_q;
    dec_state_t dec_q, dec_d;
    logic rxd_m, rxd_s, txd_m, txd_s, txd_p;

    // Register port decode.
    wire wr_mode = link.wr && (link.addr == A_MODE);
    wire wr_flags = link.wr && (link.addr == A_FLAGS);
    wire wr_ctrl = link.wr && (link.addr == A_CTRL);
    wire trim_open = (ctrl_q[C_UNLOCK_LO +: 2] == TRIM_UNLOCKED) && ctrl_q[C_OSC_MEAS];
    wire wr_cfg = link.wr && (link.addr >= A_QUANTA) && (link.addr <= A_MATCH_DATA) &&
                  (link.addr != A_OSC_HI) && (link.addr != A_OSC_LO) &&
                  (((link.addr != A_TRIM) && (link.addr != A_TRIM_OPT)) || trim_open);

    // Effective transceiver behaviour.
    wire fd_tol = ctrl_q[C_FD_TOL];
    wire err_dis = ctrl_q[C_ERR_DIS];
    wire cfg_err = flags_q[F_CFG_ERR];
    wire swk_on = selective(mode_q) && !cfg_err;
    wire wk_capable = (mode_q == MODE_WK) || ((mode_q == MODE_SWK) && cfg_err);

    // Bus silence timer runs while the synchronised receive line stays recessive.
    wire sil_expire = rxd_s && (sil_q == SILENCE_W'(SILENCE_CNT - 1));
    assign sil_d = !rxd_s ? '0 : (sil_expire || sil_q == SILENCE_W'(SILENCE_CNT)) ?
                   SILENCE_W'(SILENCE_CNT) : sil_q + 1'b1;

    // Frame tracking: the EDL bit in the control field decides the frame class.
    wire in_frame = (dec_q == DEC_FRAME);
    wire fd_seen = in_frame && i_ctrl_field && i_edl;
    wire frame_done = in_frame && i_eof;
    wire frame_bad = (frame_done && !i_frame_ok) || (fd_seen && !fd_tol);
    wire frame_good = (frame_done && i_frame_ok) || (fd_seen && fd_tol && !err_dis);
    always_comb begin
        case (dec_q)
            DEC_IDLE: dec_d = i_sof ? DEC_FRAME : DEC_IDLE;
            DEC_FRAME: dec_d = fd_seen ? DEC_SKIP : (i_eof ? DEC_IDLE : DEC_FRAME);
            DEC_SKIP: dec_d = i_eof ? DEC_IDLE : DEC_SKIP;
            default: dec_d = DEC_IDLE;
        endcase
    end

    // Error counter, active only while selective wake really runs.
    wire ecnt_ovf = swk_on && frame_bad && (ecnt_q == ECNT_OVF - 6'h01);
    wire cfg_err_clr = wr_flags && link.wdata[F_CFG_ERR];
    always_comb begin
        ecnt_d = ecnt_q;
        if (fd_tol && err_dis) begin
            ecnt_d = 6'h00;
        end else if (cfg_err_clr && ecnt_q == ECNT_OVF) begin
            ecnt_d = 6'h00;
        end else if (swk_on && frame_bad) begin
            ecnt_d = ecnt_q + 6'h01;
        end else if (swk_on && frame_good && ecnt_q != 6'h00 && ecnt_q != ECNT_OVF) begin
            ecnt_d = ecnt_q - 6'h01;
        end
    end

    // Wake sources; an FD frame never reaches frame_done, so it cannot cause a frame wake.
    wire pat_wake = armed_q && wk_capable && i_wake_pattern;
    wire frm_wake = armed_q && swk_on && frame_done && i_frame_ok && i_frame_match;
    wire ovf_wake = armed_q && ecnt_ovf;
    wire any_wake = pat_wake || frm_wake || ovf_wake;
    wire other_restart = i_restart && i_restart_from_sleep && !flags_q[F_BUS_WAKE];

    // Flags: hardware set wins over a same-cycle write-one-to-clear.
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = flags_q & ~link.wdata[3:0];
        end
        if (other_restart) begin
            flags_d[F_BUS_WAKE] = 1'b0;
            flags_d[F_WAKE_PATTERN] = 1'b0;
            flags_d[F_WAKE_FRAME] = 1'b0;
        end
        if (any_wake) begin
            flags_d[F_BUS_WAKE] = 1'b1;
        end
        if (pat_wake || (frm_wake && silence_seen_q)) begin
            flags_d[F_WAKE_PATTERN] = 1'b1;
        end
        if (frm_wake) begin
            flags_d[F_WAKE_FRAME] = 1'b1;
        end
        if (ovf_wake) begin
            flags_d[F_CFG_ERR] = 1'b1;
        end
        if (i_restart && !i_restart_from_sleep) begin
            flags_d[F_CFG_ERR] = selective(mode_q);
        end else if (other_restart && selective(mode_q)) begin
            flags_d[F_CFG_ERR] = 1'b1;
        end
    end

    // Mode field: fail-safe over restart over sleep entry over software.
    always_comb begin
        mode_d = mode_q;
        if (i_failsafe_entry) begin
            mode_d = MODE_WK;
        end else if (i_restart && !i_restart_from_sleep) begin
            if (mode_q[1:0] == 2'b00) begin
                mode_d = mode_q;
            end else if (mode_q[MODE_SEL_BIT]) begin
                mode_d = MODE_SWK;
            end else begin
                mode_d = MODE_WK;
            end
        end else if (i_sleep_entry && mode_q[1:0] != 2'b00) begin
            mode_d = mode_q[MODE_SEL_BIT] ? MODE_SWK : MODE_WK;
        end else if (wr_mode) begin
            mode_d = link.wdata[2:0];
        end
    end

    // A wake disarms the transceiver until a mode write or sleep entry rearms it.
    assign armed_d = (wr_mode || i_sleep_entry) ? 1'b1 : (any_wake ? 1'b0 : armed_q);
    assign silence_seen_d = (wr_mode || i_sleep_entry) ? 1'b0 : (silence_seen_q || sil_expire);

    // Control bits; the count disable clears itself on silence.
    always_comb begin
        ctrl_d = wr_ctrl ? link.wdata : ctrl_q;
        if (sil_expire) begin
            ctrl_d[C_ERR_DIS] = 1'b0;
        end
        if (i_failsafe_entry) begin
            ctrl_d[C_FD_TOL] = ctrl_q[C_FD_TOL];
        end
    end

    // Oscillator measure: count cycles while the transmit pin is held low.
    wire meas_on = ctrl_q[C_OSC_MEAS] && (mode_q[1:0] == 2'b00);
    assign osc_d = !meas_on ? osc_q : (txd_p && !txd_s) ? 16'h0001 :
                   (!txd_s && osc_q != 16'hffff) ? osc_q + 16'h0001 : osc_q;

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rdata_d = 8'h00;
        if (link.rd) begin
            case (link.addr)
                A_MODE: rdata_d = {5'h00, mode_q};
                A_FLAGS: rdata_d = {4'h0, flags_q};
                A_ECNT: rdata_d = {2'h0, ecnt_q};
                A_CTRL: rdata_d = ctrl_q;
                A_OSC_HI: rdata_d = osc_q[15:8];
                A_OSC_LO: rdata_d = osc_q[7:0];
                default: rdata_d = (link.addr >= A_QUANTA && link.addr <= A_MATCH_DATA) ?
                                   cfg_q[link.addr] : 8'h00;
            endcase
        end
    end
    assign link.rdata = rdata_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
            txd_m <= 1'b1;
            txd_s <= 1'b1;
            txd_p <= 1'b1;
        end else begin
            rxd_m <= i_rxd;
            rxd_s <= rxd_m;
            txd_m <= link.transmit_input_pin;
            txd_s <= txd_m;
            txd_p <= txd_s;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= MODE_RST;
            flags_q <= 4'h0;
            ecnt_q <= 6'h00;
            ctrl_q <= CTRL_RST;
            armed_q <= 1'b0;
            silence_seen_q <= 1'b0;
            sil_q <= '0;
            osc_q <= 16'h0000;
            rdata_q <= 8'h00;
            wake_q <= 1'b0;
            dec_q <= DEC_IDLE;
        end else begin
            mode_q <= mode_d;
            flags_q <= flags_d;
            ecnt_q <= ecnt_d;
            ctrl_q <= ctrl_d;
            armed_q <= armed_d;
            silence_seen_q <= silence_seen_d;
            sil_q <= sil_d;
            osc_q <= osc_d;
            rdata_q <= rdata_d;
            wake_q <= any_wake;
            dec_q <= dec_d;
        end
    end

    // Software-owned configuration bytes for timing, trim and frame matching.
    for (genvar a = A_QUANTA; a <= A_MATCH_DATA; a++) begin : g_cfg
        always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                cfg_q[a] <= (a == A_SAMPLE) ? SAMPLE_RST : 8'h00;
            end else if (wr_cfg && link.addr == 5'(a)) begin
                cfg_q[a] <= link.wdata;
            end
        end
    end

    assign o_can_wake = wake_q;
    assign o_swk_active = swk_on;
    assign o_decoder_ready = (dec_q == DEC_IDLE);
    assign o_fd_tolerant_enable = ctrl_q[C_FD_TOL];
    assign o_wake_receiver_select = ctrl_q[C_RX_SEL];
    assign o_bit_quanta = cfg_q[A_QUANTA];
    assign o_sample_point = cfg_q[A_SAMPLE];
    assign o_recovery_clock = cfg_q[A_RCLK];
    assign o_osc_trim_value = cfg_q[A_TRIM];
    assign o_osc_trim_option = cfg_q[A_TRIM_OPT];
    assign o_match_identifier = cfg_q[A_MATCH_ID];
    assign o_match_identifier_mask = cfg_q[A_MATCH_MASK];
    assign o_match_length = cfg_q[A_MATCH_LEN];
    assign o_match_payload = cfg_q[A_MATCH_DATA];

endmodule : swk_device_end
`default_nettype wire

//--- swk_link_chk.sv
// Checker for the register link between the host end and the device end.
// Assumes it sees only the link signals plus the shared clock and reset.
`timescale 1ns/1ns
`default_nettype none
module swk_link_chk
    import swk_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic transmit_input_pin
);
    // Shadow of the pure configuration bytes, rebuilt from link writes.
    logic [7:0] shd_q [16];
    logic [7:0] ctrl_q;
    wire cfg_sel = addr inside {A_QUANTA, A_SAMPLE, A_RCLK, A_MATCH_ID, A_MATCH_MASK,
        A_MATCH_LEN, A_MATCH_DATA};
    wire trim_sel = (addr == A_TRIM) || (addr == A_TRIM_OPT);
    wire trim_open = (ctrl_q[5:4] == TRIM_UNLOCKED) && ctrl_q[C_OSC_MEAS];
    wire [7:0] rd_shadow = shd_q[addr[3:0]];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < 16; i++) shd_q[i] <= 8'h00;
            shd_q[5] <= SAMPLE_RST;
            ctrl_q <= CTRL_RST;
        end else if (wr && !addr[4]) begin
            if (addr == A_CTRL) ctrl_q <= wdata;
            if (cfg_sel || (trim_sel && trim_open)) shd_q[addr[3:0]] <= wdata;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    strobe_excl_a: assert property (!(wr && rd))
        else $error("write and read strobes together");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    unmapped_read_a: assert property (rd && addr == 5'h0f |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    host_local_a: assert property (!((wr || rd) && addr[4]))
        else $error("host-local access reached the device");
    mode_width_a: assert property (rd && addr == A_MODE |=> rdata[7:3] == 5'h00)
        else $error("mode read has stray bits");
    flags_width_a: assert property (rd && addr == A_FLAGS |=> rdata[7:4] == 4'h0)
        else $error("flag read has stray bits");
    ecnt_ovf_a: assert property (rd && addr == A_ECNT |=>
        rdata[7:6] == 2'h0 && (!rdata[5] || rdata[4:0] == 5'h00))
        else $error("error count read malformed");
    trim_lock_a: assert property (rd && trim_sel |=> rdata == $past(rd_shadow))
        else $error("trim register changed while locked");
    cfg_keep_a: assert property (rd && cfg_sel |=> rdata == $past(rd_shadow))
        else $error("configuration byte readback differs");
    pin_hold_a: assert property ($fell(transmit_input_pin) |-> !transmit_input_pin [*8])
        else $error("measurement pulse too short");
endmodule : swk_link_chk
`default_nettype wire

//--- can_selective_wake_control_tb.sv
// Testbench joining the host end and the device end through the link.
// Assumes the device's frame events come from this bench on the same clock.
`timescale 1ns/1ns
`default_nettype none
module can_selective_wake_control_tb
    import swk_pkg::*;
;
    localparam int unsigned SIL = 50;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] ev = 8'h00;
    logic sleep_q = 1'b0, edl = 1'b0, ok = 1'b0, match = 1'b0, rxd = 1'b0;
    logic [7:0] rdata, v, h, l;
    logic busy, can_wake, swk_act, dec_rdy;
    int error_cnt = 0, checks = 0, wakes = 0, cnt, w0, n;
    logic [3:0] e;

    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) if (can_wake === 1'b1) wakes <= wakes + 1;

    swk_link_if link ();
    swk_host_end swk_host_end_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_pulse_busy(busy),
        .link(link.host));
    swk_device_end #(.SILENCE_CNT(SIL)) swk_device_end_inst (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .link(link.dev), .i_rxd(rxd), .i_restart(ev[0]),
        .i_restart_from_sleep(sleep_q), .i_sleep_entry(ev[1]), .i_failsafe_entry(ev[2]),
        .i_sof(ev[3]), .i_ctrl_field(ev[4]), .i_edl(edl), .i_eof(ev[5]), .i_frame_ok(ok),
        .i_frame_match(match), .i_wake_pattern(ev[6]), .o_can_wake(can_wake),
        .o_swk_active(swk_act), .o_decoder_ready(dec_rdy), .o_fd_tolerant_enable(),
        .o_wake_receiver_select(), .o_bit_quanta(), .o_sample_point(), .o_recovery_clock(),
        .o_osc_trim_value(), .o_osc_trim_option(), .o_match_identifier(),
        .o_match_identifier_mask(), .o_match_length(), .o_match_payload());
    swk_link_chk swk_link_chk_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
        .transmit_input_pin(link.transmit_input_pin));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Extra idle cycles let a late wake pulse land before the caller counts it.
    task automatic pulse(input logic [7:0] m);
        @(posedge i_clk);
        ev <= m;
        @(posedge i_clk);
        ev <= 8'h00;
        repeat (2) @(posedge i_clk);
    endtask : pulse

    task automatic frame(input logic fd, input logic k, input logic mt);
        @(posedge i_clk);
        edl <= fd;
        ok <= k;
        match <= mt;
        ev <= 8'h08;
        @(posedge i_clk);
        ev <= 8'h10;
        @(posedge i_clk);
        ev <= 8'h20;
        #1 if (fd) chk({7'h00, dec_rdy}, 8'h00);
        @(posedge i_clk);
        ev <= 8'h00;
        #1 chk({7'h00, dec_rdy}, 8'h01);
        repeat (2) @(posedge i_clk);
    endtask : frame

    function automatic logic [3:0] restart_exp(input logic [2:0] m);
        if (m[1:0] == 2'h0) return {1'b0, m};
        if (!m[2]) return {1'b0, MODE_WK};
        return {1'b1, MODE_SWK};
    endfunction : restart_exp

    task automatic final_report();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (30000) @(posedge i_clk);
        error_cnt++;
        final_report();
    end

    initial begin
        void'($urandom(89874));
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(A_MODE, v); chk(v, {5'h00, MODE_RST});
        rd(A_SAMPLE, v); chk(v, SAMPLE_RST);
        for (int m = 0; m < 8; m++) begin
            wr(A_FLAGS, 8'h0f);
            wr(A_MODE, 8'(m));
            pulse(8'h01);
            e = restart_exp(3'(m));
            rd(A_MODE, v); chk(v, {5'h00, e[2:0]});
            rd(A_FLAGS, v); chk(v, {4'h0, e[3], 3'h0});
        end
        pulse(8'h04);
        rd(A_MODE, v); chk(v, {5'h00, MODE_WK});
        wr(A_FLAGS, 8'h0f); wr(A_MODE, 8'h01); w0 = wakes; pulse(8'h40);
        rd(A_FLAGS, v); chk(v, 8'h03);
        chk(8'(wakes - w0), 8'h01);
        wr(A_FLAGS, 8'h0f); wr(A_MODE, 8'h05); pulse(8'h01); pulse(8'h02);
        w0 = wakes; pulse(8'h40);
        rd(A_FLAGS, v); chk(v, 8'h0b);
        chk(8'(wakes - w0), 8'h01);
        wr(A_FLAGS, 8'h0f); wr(A_MODE, 8'h05);
        @(posedge i_clk) sleep_q <= 1'b1;
        pulse(8'h01);
        sleep_q <= 1'b0;
        rd(A_FLAGS, v); chk(v, 8'h08);
        rd(A_MODE, v); chk(v, {5'h00, MODE_SWK});
        wr(A_FLAGS, 8'h0f); wr(A_MODE, 8'h05);
        #1 chk({7'h00, swk_act}, 8'h01);
        w0 = wakes; frame(1'b0, 1'b1, 1'b1);
        rd(A_FLAGS, v); chk(v, 8'h05);
        chk(8'(wakes - w0), 8'h01);
        wr(A_FLAGS, 8'h0f); wr(A_MODE, 8'h05); cnt = 0;
        repeat (24) begin
            n = $urandom % 2;
            frame(1'b0, n[0], 1'b0);
            cnt = n[0] ? (cnt > 0 ? cnt - 1 : 0) : cnt + 1;
        end
        rd(A_ECNT, v); chk(v, 8'(cnt));
        while (cnt < 31) begin
            frame(1'b0, 1'b0, 1'b0);
            cnt++;
        end
        w0 = wakes; frame(1'b0, 1'b0, 1'b0);
        rd(A_ECNT, v); chk(v, {2'h0, ECNT_OVF});
        rd(A_FLAGS, v); chk(v, 8'h09);
        chk(8'(wakes - w0), 8'h01);
        wr(A_FLAGS, 8'h08); rd(A_ECNT, v); chk(v, 8'h00);
        wr(A_FLAGS, 8'h0f); wr(A_MODE, 8'h05); wr(A_CTRL, 8'h01);
        frame(1'b0, 1'b0, 1'b0); frame(1'b0, 1'b0, 1'b0);
        w0 = wakes; frame(1'b1, 1'b1, 1'b1);
        rd(A_ECNT, v); chk(v, 8'h01);
        chk(8'(wakes - w0), 8'h00);
        wr(A_CTRL, 8'h00); frame(1'b1, 1'b1, 1'b0);
        rd(A_ECNT, v); chk(v, 8'h02);
        wr(A_CTRL, 8'h03); frame(1'b0, 1'b0, 1'b0);
        rd(A_ECNT, v); chk(v, 8'h00);
        @(posedge i_clk) rxd <= 1'b1;
        repeat (SIL + 10) @(posedge i_clk);
        rxd <= 1'b0;
        rd(A_CTRL, v); chk(v, 8'h01);
        wr(A_CTRL, 8'h04); wr(A_MODE, 8'h00); wr(A_PULSE_LEN, 8'h0c); wr(A_PULSE_GO, 8'h01);
        n = 0;
        repeat (2) @(posedge i_clk);
        while (busy === 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        repeat (4) @(posedge i_clk);
        rd(A_OSC_HI, h); rd(A_OSC_LO, l);
        chk((h == 8'h00 && l >= 8'h0a && l <= 8'h0e) ? 8'h01 : l, 8'h01);
        wr(A_OSC_LO, ~l); rd(A_OSC_LO, v); chk(v, l);
        wr(A_TRIM, 8'h5a); rd(A_TRIM, v); chk(v, 8'h00);
        wr(A_CTRL, 8'h34); wr(A_TRIM, 8'h5a); wr(A_TRIM_OPT, 8'ha5);
        rd(A_TRIM, v); chk(v, 8'h5a);
        rd(A_TRIM_OPT, v); chk(v, 8'ha5);
        wr(A_CTRL, 8'h04); wr(A_TRIM, 8'h11); rd(A_TRIM, v); chk(v, 8'h5a);
        for (int i = 0; i < 7; i++) begin
            h = 8'($urandom);
            l = {3'h0, (i < 3) ? 5'(4 + i) : 5'(8 + i)};
            wr(l[4:0], h); rd(l[4:0], v); chk(v, h);
        end
        rd(5'h0f, v); chk(v, 8'h00);
        rd(A_PULSE_GO, v); chk(v, 8'h00);
        final_report();
    end
endmodule : can_selective_wake_control_tb
`default_nettype wire
